/* bench/tb.sv */
// self-checking bench for the coarse gain register bank
`timescale 1ns/1ps

module tb;
  // =====================================================================
  // clock, reset and bus signals
  // =====================================================================
  logic                  sys_clk;
  logic                  reset_n;
  logic                  hsel;
  logic [31:0]           haddr;
  logic [1:0]            htrans;
  logic                  hwrite;
  logic [2:0]            hsize;
  logic [31:0]           hwdata;
  logic                  hreadyout;
  logic                  hresp;
  logic [31:0]           hrdata;
  cgc_pkg::cgc_gain_type txCoarse;
  cgc_pkg::cgc_gain_type rxCoarse;
  int                    fails;
  int                    checkCount;
  int                    cycles;
  int                    seed;
  logic [31:0]           rd;
  logic [31:0]           wd;
  logic [31:0]           txAddr;
  logic [31:0]           rxAddr;
  logic [4:0]            txField;

  cgc_coarse_gain dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .txCoarse(txCoarse), .rxCoarse(rxCoarse));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // =====================================================================
  // expectations and comparisons
  // =====================================================================
  function automatic cgc_pkg::cgc_gain_type exp_gain(input logic [4:0] f);
    cgc_pkg::cgc_gain_type g;
    g = '0;
    if (f[3:0] != 4'h0) begin
      g.attenuate = f[4];
      // gain saturates once both upper magnitude bits are set
      g.levelDb = (!f[4] && f[3:2] == 2'h3) ? 4'hC : f[3:0];
      g.netDb = f[4] ? -$signed({2'h0, g.levelDb}) : $signed({2'h0, g.levelDb});
    end
    return g;
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_gain(input cgc_pkg::cgc_gain_type got, input cgc_pkg::cgc_gain_type exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t gain got %h expected %h", $time, got, exp);
    end
  endtask

  // =====================================================================
  // bus master: address phase, then data phase, each held until hready
  // =====================================================================
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] sz, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    htrans <= cgc_pkg::HTRANS_NONSEQ;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
    #1;
  endtask

  // write one path, then check its decoded stage and the read-back word
  task automatic wr_check(input logic path, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, path ? rxAddr : txAddr, d, cgc_pkg::HSIZE_WORD, r);
    if (!path) begin
      txField = d[4:0];
      cmp_gain(txCoarse, exp_gain(d[4:0]));
    end else begin
      cmp_gain(rxCoarse, exp_gain(d[4:0]));
    end
    xfer(1'b0, path ? rxAddr : txAddr, 32'h0, cgc_pkg::HSIZE_WORD, r);
    cmp_word(r, {27'h0, d[4:0]});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("BAD %0t run did not finish", $time);
      report_and_stop();
    end
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = cgc_pkg::HSIZE_WORD; hwdata = 32'h0;
    fails = 0; checkCount = 0; cycles = 0; seed = 32'h4D09;
    txAddr = {22'h0, cgc_pkg::TX_COARSE_ADDR};
    rxAddr = {22'h0, cgc_pkg::RX_COARSE_ADDR};
    txField = 5'h00;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp_gain(txCoarse, '0);
    cmp_gain(rxCoarse, '0);
    @(posedge sys_clk);
    xfer(1'b0, txAddr, 32'h0, cgc_pkg::HSIZE_WORD, rd);
    cmp_word(rd, 32'h0);
    xfer(1'b0, rxAddr, 32'h0, cgc_pkg::HSIZE_WORD, rd);
    cmp_word(rd, 32'h0);
    // every field code on both paths, junk in the upper bits
    for (int i = 0; i < 64; i++) begin
      wd = $random(seed);
      wr_check(i[5], {wd[31:5], i[4:0]});
    end
    // unmapped, out-of-range and non-word writes must leave tx alone
    wd = 32'h0A;
    xfer(1'b1, txAddr + 32'h8, wd, cgc_pkg::HSIZE_WORD, rd);
    xfer(1'b1, txAddr | 32'h400, wd, cgc_pkg::HSIZE_WORD, rd);
    xfer(1'b1, txAddr, wd, 3'h0, rd);
    cmp_gain(txCoarse, exp_gain(txField));
    xfer(1'b0, txAddr + 32'h8, 32'h0, cgc_pkg::HSIZE_WORD, rd);
    cmp_word(rd, 32'h0);
    xfer(1'b0, txAddr, 32'h0, cgc_pkg::HSIZE_WORD, rd);
    cmp_word(rd, {27'h0, txField});
    // random traffic with saturation corners mixed in
    for (int i = 0; i < 40; i++) begin
      wd = $random(seed);
      if (i % 8 == 0) wd[4:2] = 3'h3;
      wr_check(wd[31], wd);
    end
    report_and_stop();
  end
endmodule // tb

/* rtl/cgc_coarse_gain.sv */
// AHB-Lite register bank for the transmit and receive coarse gain stages
`timescale 1ns/1ps

module cgc_coarse_gain #(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned DATA_W = 32
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [DATA_W-1:0]    hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [DATA_W-1:0]         hrdata,
  // resolved coarse stage settings
  output cgc_pkg::cgc_gain_type     txCoarse,
  output cgc_pkg::cgc_gain_type     rxCoarse
);

  // =====================================================================
  // elaboration checks
  // =====================================================================
  if (DATA_W != 32) begin : g_bad_data
    $error("cgc_coarse_gain: data width must be 32");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("cgc_coarse_gain: address too narrow for the register map");
  end

  // =====================================================================
  // state
  // =====================================================================
  cgc_pkg::cgc_state_type state_ff;
  cgc_pkg::cgc_state_type nxt_state;

  logic addrPhase;
  logic hitTx;
  logic hitRx;
  logic upperZero;

  // =====================================================================
  // decode of one coarse stage into a signed dB figure
  // =====================================================================
  function automatic cgc_pkg::cgc_gain_type decodeStage(input cgc_pkg::cgc_path_type r);
    cgc_pkg::cgc_gain_type g;
    g = '0;
    // a zero code bypasses the stage whatever the polarity says
    if (r.magnitude != cgc_pkg::MAGNITUDE_OFF) begin
      if (r.polarity) begin
        // attenuation follows the code all the way to the top
        g.attenuate = 1'b1;
        g.levelDb   = r.magnitude;
        g.netDb     = -$signed({2'h0, r.magnitude});
      end else begin
        // gain tops out earlier: every 11xx code is the same 12 dB
        if (r.magnitude[3:2] == cgc_pkg::SATURATE_TOP) begin
          g.levelDb = cgc_pkg::GAIN_MAX_DB;
        end else begin
          g.levelDb = r.magnitude;
        end
        g.netDb = $signed({2'h0, g.levelDb});
      end
    end
    return g;
  endfunction

  function automatic logic [31:0] readWord(input cgc_pkg::cgc_path_type r);
    logic [31:0] w;
    w = '0;
    // bits above the field stay zero on every read
    w[cgc_pkg::FIELD_TOP:0] = r;
    return w;
  endfunction

  // =====================================================================
  // address phase qualification
  // =====================================================================
  // only whole-word transfers are honoured; narrower ones complete OKAY
  // with no effect, which keeps the byte-lane logic out of the block
  assign addrPhase = hsel && hready && htrans[1] && (hsize == cgc_pkg::HSIZE_WORD);
  assign upperZero = (haddr[ADDR_W-1:10] == '0);
  assign hitTx     = upperZero && (haddr[9:0] == cgc_pkg::TX_COARSE_ADDR);
  assign hitRx     = upperZero && (haddr[9:0] == cgc_pkg::RX_COARSE_ADDR);

  // =====================================================================
  // next state
  // =====================================================================
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.wrTx = 1'b0;
    nxt_state.wrRx = 1'b0;

    // data phase of a write: hwdata is valid only now
    if (state_ff.wrTx) begin
      nxt_state.txReg.polarity  = hwdata[cgc_pkg::POLARITY_BIT];
      nxt_state.txReg.magnitude = hwdata[cgc_pkg::MAGNITUDE_MSB:cgc_pkg::MAGNITUDE_LSB];
    end
    if (state_ff.wrRx) begin
      nxt_state.rxReg.polarity  = hwdata[cgc_pkg::POLARITY_BIT];
      nxt_state.rxReg.magnitude = hwdata[cgc_pkg::MAGNITUDE_MSB:cgc_pkg::MAGNITUDE_LSB];
    end

    if (addrPhase) begin
      nxt_state.wrTx = hwrite && hitTx;
      nxt_state.wrRx = hwrite && hitRx;
      if (!hwrite) begin
        // read from the updated copy so a read right behind a write sees it
        if (hitTx) begin
          nxt_state.rdData = readWord(nxt_state.txReg);
        end else if (hitRx) begin
          nxt_state.rdData = readWord(nxt_state.rxReg);
        end else begin
          nxt_state.rdData = '0;
        end
      end
    end

    nxt_state.txGain = decodeStage(nxt_state.txReg);
    nxt_state.rxGain = decodeStage(nxt_state.rxReg);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff       <= '0;
      state_ff.txReg <= cgc_pkg::COARSE_RESET;
      state_ff.rxReg <= cgc_pkg::COARSE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  // zero wait states: every transfer finishes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = cgc_pkg::HRESP_OKAY;
  assign hrdata    = state_ff.rdData;
  assign txCoarse  = state_ff.txGain;
  assign rxCoarse  = state_ff.rxGain;

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence txWrite;
    addrPhase && hwrite && hitTx;
  endsequence

  sequence rxWrite;
    addrPhase && hwrite && hitRx;
  endsequence

  sequence anyRead;
    addrPhase && !hwrite;
  endsequence

  sequence txRead;
    addrPhase && !hwrite && hitTx;
  endsequence

  sequence rxRead;
    addrPhase && !hwrite && hitRx;
  endsequence

  tx_polarity_select_a: assert property (
    txWrite ##1 (hwdata[4] && (hwdata[3:0] != 4'h0))
    |=> txCoarse.attenuate && (txCoarse.netDb < 0) && (txCoarse.levelDb == $past(hwdata[3:0])))
    else $error("tx polarity set but no attenuation");

  tx_gain_side_a: assert property (
    txWrite ##1 (!hwdata[4] && (hwdata[3:0] != 4'h0))
    |=> !txCoarse.attenuate && (txCoarse.netDb > 0))
    else $error("tx polarity clear but no gain");

  tx_zero_bypass_a: assert property (
    (state_ff.txReg.magnitude == 4'h0)
    |-> (txCoarse.netDb == 0) && !txCoarse.attenuate && (txCoarse.levelDb == 4'h0))
    else $error("tx zero code did not bypass the stage");

  tx_one_step_a: assert property (
    txWrite ##1 (hwdata[4:0] == 5'h01) |=> (txCoarse.netDb == 6'sh01) [*2])
    else $error("tx code one is not one dB of gain");

  tx_step_linear_a: assert property (
    txWrite ##1 (!hwdata[4] && (hwdata[3:2] != 2'h3))
    |=> (txCoarse.levelDb == $past(hwdata[3:0])))
    else $error("tx gain not one dB per step");

  tx_gain_sat_a: assert property (
    txWrite ##1 (!hwdata[4] && (hwdata[3:2] == 2'h3))
    |=> (txCoarse.netDb == 6'sh0C) && (txCoarse.levelDb == 4'hC))
    else $error("tx gain did not saturate at 12 dB");

  tx_atten_max_a: assert property (
    txWrite ##1 (hwdata[4:0] == 5'h1F) |=> (txCoarse.netDb == 6'sh31))
    else $error("tx full code is not 15 dB of attenuation");

  rx_polarity_select_a: assert property (
    rxWrite ##1 (hwdata[4] && (hwdata[3:0] != 4'h0))
    |=> rxCoarse.attenuate && (rxCoarse.netDb == -$signed({2'h0, $past(hwdata[3:0])})))
    else $error("rx polarity set but no attenuation");

  rx_zero_bypass_a: assert property (
    rxWrite ##1 (hwdata[3:0] == 4'h0)
    |=> (rxCoarse.netDb == 0) && !rxCoarse.attenuate)
    else $error("rx zero code did not bypass the stage");

  rx_step_linear_a: assert property (
    rxWrite ##1 (!hwdata[4] && (hwdata[3:2] != 2'h3))
    |=> (rxCoarse.netDb == $signed({2'h0, $past(hwdata[3:0])})))
    else $error("rx gain not one dB per step");

  rx_gain_sat_a: assert property (
    rxWrite ##1 (!hwdata[4] && (hwdata[3:2] == 2'h3))
    |=> (rxCoarse.netDb == 6'sh0C))
    else $error("rx gain did not saturate at 12 dB");

  rx_atten_max_a: assert property (
    rxWrite ##1 (hwdata[4:0] == 5'h1F) |=> (rxCoarse.levelDb == 4'hF) && rxCoarse.attenuate)
    else $error("rx full code is not 15 dB of attenuation");

  reserved_read_zero_a: assert property (
    anyRead |=> (hrdata[31:5] == 27'h0000000))
    else $error("reserved bits read nonzero");

  reset_value_a: assert property (
    $rose(reset_n) |-> (state_ff.txReg == 5'h00) && (state_ff.rxReg == 5'h00))
    else $error("coarse registers not zero after reset");

  // the master never pipelines, so a read follows a write two edges later
  tx_readback_a: assert property (
    txWrite ##2 txRead
    |=> (hrdata[4:0] == $past(hwdata[4:0], 2)))
    else $error("tx read right after write returned stale data");

  unmapped_read_a: assert property (
    (addrPhase && !hwrite && !hitTx && !hitRx) |=> (hrdata == 32'h00000000))
    else $error("unmapped read not zero");

  bus_always_ready_a: assert property (
    hreadyout && (hresp == cgc_pkg::HRESP_OKAY))
    else $error("slave stalled or answered with an error");

  rx_gain_side_a: assert property (
    rxWrite ##1 (!hwdata[4] && (hwdata[3:0] != 4'h0))
    |=> !rxCoarse.attenuate && (rxCoarse.netDb > 0))
    else $error("rx polarity clear but no gain");

  rx_one_step_a: assert property (
    rxWrite ##1 (hwdata[4:0] == 5'h01)
    |=> (rxCoarse.netDb == 6'sh01) && (rxCoarse.levelDb == 4'h1))
    else $error("rx code one is not one dB of gain");

  tx_atten_step_a: assert property (
    txWrite ##1 hwdata[4]
    |=> (txCoarse.netDb == -$signed({2'h0, $past(hwdata[3:0])})))
    else $error("tx attenuation does not follow the code");

  rx_atten_step_a: assert property (
    rxWrite ##1 (hwdata[4] && (hwdata[3:0] != 4'h0))
    |=> rxCoarse.attenuate && (rxCoarse.levelDb == $past(hwdata[3:0])))
    else $error("rx attenuation does not follow the code");

  tx_zero_write_a: assert property (
    txWrite ##1 (hwdata[3:0] == 4'h0)
    |=> (txCoarse.netDb == 0) && !txCoarse.attenuate)
    else $error("tx zero write did not bypass the stage");

  rx_zero_state_a: assert property (
    (state_ff.rxReg.magnitude == 4'h0)
    |-> (rxCoarse.netDb == 0) && !rxCoarse.attenuate && (rxCoarse.levelDb == 4'h0))
    else $error("rx zero code did not bypass the stage");

  // the gain side can never pass the saturation point
  tx_gain_limit_a: assert property (
    !txCoarse.attenuate
    |-> (txCoarse.levelDb <= 4'hC) && (txCoarse.netDb >= 0))
    else $error("tx gain above 12 dB");

  rx_gain_limit_a: assert property (
    !rxCoarse.attenuate
    |-> (rxCoarse.levelDb <= 4'hC) && (rxCoarse.netDb >= 0))
    else $error("rx gain above 12 dB");

  // a setting moves only on the edge that closes a write data phase to it
  tx_setting_held_a: assert property (
    !(addrPhase && hwrite && hitTx)
    |=> ##1 $stable(txCoarse))
    else $error("tx setting moved without a write");

  rx_setting_held_a: assert property (
    !(addrPhase && hwrite && hitRx)
    |=> ##1 $stable(rxCoarse))
    else $error("rx setting moved without a write");

  // read data stands through its data phase and until the next read is taken
  read_data_held_a: assert property (
    !(addrPhase && !hwrite)
    |=> $stable(hrdata))
    else $error("read data changed without a read");

  rx_readback_a: assert property (
    rxWrite ##2 rxRead
    |=> (hrdata[4:0] == $past(hwdata[4:0], 2)))
    else $error("rx read after write returned stale data");

  tx_read_field_a: assert property (
    txRead ##0 !state_ff.wrTx
    |=> (hrdata == {27'h0, $past(state_ff.txReg)}))
    else $error("tx read does not return the stored field");

  rx_read_field_a: assert property (
    rxRead ##0 !state_ff.wrRx
    |=> (hrdata == {27'h0, $past(state_ff.rxReg)}))
    else $error("rx read does not return the stored field");

  // refused transfers must not arm a data-phase write strobe
  narrow_write_dropped_a: assert property (
    (hsel && hready && htrans[1] && hwrite && (hsize != cgc_pkg::HSIZE_WORD))
    |=> !state_ff.wrTx && !state_ff.wrRx)
    else $error("narrow write was not dropped");

  unmapped_write_dropped_a: assert property (
    (addrPhase && hwrite && !hitTx && !hitRx)
    |=> !state_ff.wrTx && !state_ff.wrRx)
    else $error("unmapped write was not dropped");

  reset_outputs_zero_a: assert property (
    $rose(reset_n)
    |-> (txCoarse == '0) && (rxCoarse == '0) && (hrdata == 32'h00000000))
    else $error("outputs not zero after reset");

endmodule // cgc_coarse_gain

/* rtl/cgc_pkg.sv */
// constants and carrier types for the coarse path gain control registers
// =====================================================================
// =====================================================================
package cgc_pkg;

  // =====================================================================
  // register map: printed offsets are indices, byte address is four times
  // =====================================================================
  localparam logic [7:0] TX_COARSE_INDEX = 8'h26;
  localparam logic [7:0] RX_COARSE_INDEX = 8'h27;
  localparam logic [9:0] TX_COARSE_ADDR  = {TX_COARSE_INDEX, 2'h0};
  localparam logic [9:0] RX_COARSE_ADDR  = {RX_COARSE_INDEX, 2'h0};

  // =====================================================================
  // field layout and reset values
  // =====================================================================
  localparam int unsigned POLARITY_BIT  = 4;
  localparam int unsigned MAGNITUDE_MSB = 3;
  localparam int unsigned MAGNITUDE_LSB = 0;
  localparam int unsigned FIELD_TOP     = 4;
  localparam logic [4:0]  COARSE_RESET  = 5'h00;
  localparam logic [3:0]  MAGNITUDE_OFF = 4'h0;
  localparam logic [1:0]  SATURATE_TOP  = 2'h3;
  localparam logic [3:0]  GAIN_MAX_DB   = 4'hC;

  // =====================================================================
  // AHB-Lite encodings
  // =====================================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // =====================================================================
  // carrier types
  // =====================================================================
  typedef struct packed {
    logic       polarity;
    logic [3:0] magnitude;
  } cgc_path_type;

  typedef struct packed {
    logic              attenuate;
    logic [3:0]        levelDb;
    logic signed [5:0] netDb;
  } cgc_gain_type;

  typedef struct packed {
    cgc_path_type txReg;
    cgc_path_type rxReg;
    logic         wrTx;
    logic         wrRx;
    logic [31:0]  rdData;
    cgc_gain_type txGain;
    cgc_gain_type rxGain;
  } cgc_state_type;

endpackage
